// ===== common/osp_pkg.sv
// Package for the one-shot pulse channel: register map, field positions,
// reset values and the channel state enumeration.
// Assumes a 32-bit APB slave and a 16-bit channel counter.
`default_nettype none

package osp_pkg;

  localparam int CNT_W = 16;
  localparam int CEN_N = 8;
  localparam int ADDR_W = 8;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_COUNTER  = 8'h04;
  localparam logic [7:0] ADDR_PERIOD   = 8'h08;
  localparam logic [7:0] ADDR_DUTY     = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_FLAG = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h14;
  localparam logic [7:0] ADDR_STATUS   = 8'h18;

  // Control register fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_OS_BIT   = 1;
  localparam int CTRL_TSEL_BIT = 2;
  localparam int CTRL_UD_LSB   = 3;
  localparam int CTRL_CSEL_LSB = 8;
  localparam int CTRL_ACT_BIT  = 11;
  localparam int CTRL_W        = 12;

  // Values after reset
  localparam logic [CTRL_W-1:0] CTRL_RST   = 12'h800;
  localparam logic [CNT_W-1:0]  PERIOD_RST = 16'hFFFF;
  localparam logic [CNT_W-1:0]  DUTY_RST   = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_RST    = 16'h0000;
  localparam logic [1:0]        UD_UP_ONLY = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_INIT,
    ST_PULSE
  } osp_state_e;

  // Compare condition: counter at compare value minus one
  function automatic logic osp_hit(input logic [CNT_W-1:0] cnt,
                                   input logic [CNT_W-1:0] cmp);
    return cnt == (cmp - 16'h0001);
  endfunction

endpackage

`default_nettype wire

// ===== logic/osp_cen_sel.sv
// Clock enable selection and event alignment for one channel.
// Assumes enables are one-cycle pulses in the clk_i domain.
`default_nettype none
`timescale 1ns/100ps

module osp_cen_sel (
  input  wire logic                      clk_i,
  input  wire logic                      reset_i,
  input  wire logic [osp_pkg::CEN_N-1:0] cen_vec_i,
  input  wire logic [2:0]                sel_i,
  input  wire logic                      capture_i,
  input  wire logic                      chain_i,
  output logic                           cen_o,
  output logic                           capture_o,
  output logic                           chain_o
);

  logic cap_pend_q;
  logic cap_pend_d;
  logic chn_pend_q;
  logic chn_pend_d;

  // Events wait for the selected enable so a clear never lands mid-tick
  always_comb begin
    cen_o      = cen_vec_i[sel_i];
    capture_o  = cen_o & (cap_pend_q | capture_i); // RL14
    chain_o    = cen_o & (chn_pend_q | chain_i);
    cap_pend_d = (cap_pend_q | capture_i) & ~cen_o;
    chn_pend_d = (chn_pend_q | chain_i) & ~cen_o;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cap_pend_q <= 1'b0;
      chn_pend_q <= 1'b0;
    end else begin
      cap_pend_q <= cap_pend_d;
      chn_pend_q <= chn_pend_d;
    end
  end

endmodule // osp_cen_sel

`default_nettype wire

// ===== logic/osp_channel.sv
// One-shot pulse channel with two compare units and an APB register file.
// Assumes one clock, selectable enables, triggers synchronous to clk_i.
//
// Function
// RL1: In software start mode a counter write begins an inactive phase then one pulse.
// RL2: A software start's inactive phase lasts the period compare value less the written count.
// RL3: At period compare minus one the output goes active and the counter restarts at zero.
// RL4: In the pulse the output goes inactive when the counter hits duty compare minus one.
// RL5: Both compare units also raise their triggers during the inactive phase.
// RL6: Enabled compare causes raise the interrupt and set their flag bits.
// RL7: In trigger mode a chain or capture event clears the counter and starts a cycle.
// RL8: A triggered cycle's inactive phase runs until period compare minus one.
// RL9: Inactive-phase triggers appear for every later cycle whatever value was written.
// RL10: With duty compare at one the second unit fires in the inactive phase only; the code also fires it on the first pulse-phase enable.
// RL11: Software may disable, reset and re-enable the channel between cycles.
// RL12: Software may write the counter twice, zero then the start value.
// RL13: Software keeps up/down counting off when the output feeds the pattern unit.
// RL14: A capture-driven clear waits for the selected clock enable.
// RL15: The counter moves and compares are checked only on the selected enable.
// RL16: After the inactive edge the output holds and counting stops until a new start.
//
// Design decisions made here: the placing of the registers and register access over APB.
`default_nettype none
`timescale 1ns/100ps

module osp_channel (
  input  wire logic                       clk_i,
  input  wire logic                       reset_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [osp_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic                            pready_o,
  output logic [31:0]                     prdata_o,
  output logic                            pslverr_o,
  input  wire logic [osp_pkg::CEN_N-1:0]  cluster_clock_enable_i,
  input  wire logic                       chain_trigger_in_i,
  input  wire logic                       external_capture_trigger_i,
  output logic                            pulse_o,
  output logic                            compare0_trigger_o,
  output logic                            compare1_trigger_o,
  output logic                            irq_o
);

  // Bus and register state
  logic [osp_pkg::CTRL_W-1:0] ctrl_q;
  logic [osp_pkg::CTRL_W-1:0] ctrl_d;
  logic [osp_pkg::CNT_W-1:0]  period_q;
  logic [osp_pkg::CNT_W-1:0]  period_d;
  logic [osp_pkg::CNT_W-1:0]  duty_q;
  logic [osp_pkg::CNT_W-1:0]  duty_d;
  logic                       pready_d;
  logic [31:0]                prdata_d;
  logic                       pslverr_d;

  // Channel state
  osp_pkg::osp_state_e        st_q;
  osp_pkg::osp_state_e        st_d;
  logic [osp_pkg::CNT_W-1:0]  cnt_q;
  logic [osp_pkg::CNT_W-1:0]  cnt_d;
  logic                       act_q;
  logic                       act_d;
  logic                       pulse_d;
  logic                       c0_d;
  logic                       c1_d;

  // Decode and helpers
  logic                       acc;
  logic                       acc_wr;
  logic                       mapped;
  logic                       wr_cnt;
  logic                       wr_flag;
  logic                       wr_en;
  logic                       ch_en;
  logic                       sw_mode;
  logic                       hw_mode;
  logic                       hw_start;
  logic                       cen;
  logic                       cap_ev;
  logic                       chain_ev;
  logic                       hit0;
  logic                       hit1;
  logic [1:0]                 irq_flag;
  logic [1:0]                 irq_en;

  osp_cen_sel u_cen_sel (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .cen_vec_i (cluster_clock_enable_i),
    .sel_i     (ctrl_q[osp_pkg::CTRL_CSEL_LSB +: 3]),
    .capture_i (external_capture_trigger_i),
    .chain_i   (chain_trigger_in_i),
    .cen_o     (cen),
    .capture_o (cap_ev),
    .chain_o   (chain_ev)
  );

  osp_irq u_irq (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .event_i   ({compare1_trigger_o, compare0_trigger_o}),
    .flag_we_i (wr_flag),
    .en_we_i   (wr_en),
    .wdata_i   (pwdata_i[1:0]),
    .flag_o    (irq_flag),
    .en_o      (irq_en),
    .irq_o     (irq_o)
  );

  // Access phase stretched by one cycle so pready comes from a flop
  assign acc    = psel_i & penable_i & pready_o;
  assign acc_wr = acc & pwrite_i;
  assign mapped = (paddr_i == osp_pkg::ADDR_CTRL)     |
                  (paddr_i == osp_pkg::ADDR_COUNTER)  |
                  (paddr_i == osp_pkg::ADDR_PERIOD)   |
                  (paddr_i == osp_pkg::ADDR_DUTY)     |
                  (paddr_i == osp_pkg::ADDR_IRQ_FLAG) |
                  (paddr_i == osp_pkg::ADDR_IRQ_EN)   |
                  (paddr_i == osp_pkg::ADDR_STATUS);
  assign wr_cnt  = acc_wr & (paddr_i == osp_pkg::ADDR_COUNTER);
  assign wr_flag = acc_wr & (paddr_i == osp_pkg::ADDR_IRQ_FLAG);
  assign wr_en   = acc_wr & (paddr_i == osp_pkg::ADDR_IRQ_EN);

  // Mode decode; up/down counting disables both one-shot starts
  assign ch_en   = ctrl_q[osp_pkg::CTRL_EN_BIT];
  assign sw_mode = ch_en & ctrl_q[osp_pkg::CTRL_OS_BIT] & ~ctrl_q[osp_pkg::CTRL_TSEL_BIT] &
                   (ctrl_q[osp_pkg::CTRL_UD_LSB +: 2] == osp_pkg::UD_UP_ONLY);
  assign hw_mode = ch_en & ctrl_q[osp_pkg::CTRL_OS_BIT] & ctrl_q[osp_pkg::CTRL_TSEL_BIT] &
                   (ctrl_q[osp_pkg::CTRL_UD_LSB +: 2] == osp_pkg::UD_UP_ONLY);
  assign hw_start = hw_mode & (chain_ev | cap_ev); // RL7 RL14

  // Compare is purely on the live count; no history can mask a trigger
  assign hit0 = osp_pkg::osp_hit(cnt_q, period_q); // RL9
  assign hit1 = osp_pkg::osp_hit(cnt_q, duty_q); // RL9

  // Register file next state
  always_comb begin
    ctrl_d    = ctrl_q;
    period_d  = period_q;
    duty_d    = duty_q;
    pready_d  = psel_i & penable_i & ~pready_o;
    prdata_d  = 32'h0000_0000;
    pslverr_d = 1'b0;
    if (psel_i & penable_i & ~pready_o) begin
      pslverr_d = ~mapped;
      if (!pwrite_i) begin
        unique case (paddr_i)
          osp_pkg::ADDR_CTRL:     prdata_d = {20'h0_0000, ctrl_q};
          osp_pkg::ADDR_COUNTER:  prdata_d = {16'h0000, cnt_q};
          osp_pkg::ADDR_PERIOD:   prdata_d = {16'h0000, period_q};
          osp_pkg::ADDR_DUTY:     prdata_d = {16'h0000, duty_q};
          osp_pkg::ADDR_IRQ_FLAG: prdata_d = {30'h0000_0000, irq_flag};
          osp_pkg::ADDR_IRQ_EN:   prdata_d = {30'h0000_0000, irq_en};
          osp_pkg::ADDR_STATUS:   prdata_d = {29'h0000_0000, act_q, st_q};
          default:                prdata_d = 32'h0000_0000;
        endcase
      end
    end
    if (acc_wr) begin
      unique case (paddr_i)
        osp_pkg::ADDR_CTRL:   ctrl_d   = pwdata_i[osp_pkg::CTRL_W-1:0];
        osp_pkg::ADDR_PERIOD: period_d = pwdata_i[osp_pkg::CNT_W-1:0];
        osp_pkg::ADDR_DUTY:   duty_d   = pwdata_i[osp_pkg::CNT_W-1:0];
        default:              ctrl_d   = ctrl_q;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_q    <= osp_pkg::CTRL_RST;
      period_q  <= osp_pkg::PERIOD_RST;
      duty_q    <= osp_pkg::DUTY_RST;
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      period_q  <= period_d;
      duty_q    <= duty_d;
      pready_o  <= pready_d;
      prdata_o  <= prdata_d;
      pslverr_o <= pslverr_d;
    end
  end

  // Channel next state
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    act_d = act_q;
    c0_d  = 1'b0;
    c1_d  = 1'b0;
    if (!ch_en) begin
      st_d  = osp_pkg::ST_IDLE;
      act_d = 1'b0;
      if (wr_cnt) begin
        cnt_d = pwdata_i[osp_pkg::CNT_W-1:0];
      end
    end else if (wr_cnt) begin
      // Phase length is period minus written value
      cnt_d = pwdata_i[osp_pkg::CNT_W-1:0]; // RL2
      if (sw_mode) begin
        st_d  = osp_pkg::ST_INIT; // RL1
        act_d = 1'b0;
      end
    end else if (hw_start) begin
      cnt_d = osp_pkg::CNT_RST; // RL7
      st_d  = osp_pkg::ST_INIT;
      act_d = 1'b0;
    end else if (cen && st_q != osp_pkg::ST_IDLE) begin // RL15
      c0_d = hit0; // RL5
      c1_d = hit1; // RL5 RL10
      unique case (st_q)
        osp_pkg::ST_INIT: begin
          if (hit0) begin
            act_d = 1'b1; // RL3 RL8
            cnt_d = osp_pkg::CNT_RST;
            st_d  = osp_pkg::ST_PULSE;
          end else begin
            cnt_d = cnt_q + 16'h0001;
          end
        end
        osp_pkg::ST_PULSE: begin
          // Duty of one ends here, so period is never reached twice
          if (hit1) begin
            act_d = 1'b0; // RL4 RL10
            st_d  = osp_pkg::ST_IDLE; // RL16
          end else begin
            cnt_d = cnt_q + 16'h0001;
          end
        end
        default: begin
          st_d = osp_pkg::ST_IDLE;
        end
      endcase
    end
    pulse_d = act_d ~^ ctrl_d[osp_pkg::CTRL_ACT_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_q               <= osp_pkg::ST_IDLE;
      cnt_q              <= osp_pkg::CNT_RST;
      act_q              <= 1'b0;
      pulse_o            <= 1'b0;
      compare0_trigger_o <= 1'b0;
      compare1_trigger_o <= 1'b0;
    end else begin
      st_q               <= st_d;
      cnt_q              <= cnt_d;
      act_q              <= act_d;
      pulse_o            <= pulse_d;
      compare0_trigger_o <= c0_d;
      compare1_trigger_o <= c1_d;
    end
  end

  // Checks
  logic quiet;
  assign quiet = ch_en & ~wr_cnt & ~hw_start;

  sequence s_init_hit;
    quiet && cen && st_q == osp_pkg::ST_INIT && hit0;
  endsequence

  sequence s_pulse_end;
    quiet && cen && st_q == osp_pkg::ST_PULSE && hit1;
  endsequence

  sequence s_init_wait;
    quiet && st_q == osp_pkg::ST_INIT && !(cen && hit0);
  endsequence

  sequence s_pulse_hold;
    quiet && st_q == osp_pkg::ST_PULSE && !(cen && hit1);
  endsequence

  a_sw_start_load: assert property (@(posedge clk_i) disable iff (reset_i) // RL1 RL2
    wr_cnt && sw_mode |=> st_q == osp_pkg::ST_INIT && !act_q &&
                          cnt_q == $past(pwdata_i[15:0]))
    else $error("software start did not load the counter");

  a_active_edge: assert property (@(posedge clk_i) disable iff (reset_i) // RL3
    s_init_hit |=> act_q && cnt_q == 16'h0000 && st_q == osp_pkg::ST_PULSE)
    else $error("active edge missing at period match");

  a_inactive_edge: assert property (@(posedge clk_i) disable iff (reset_i) // RL4
    s_pulse_end |=> !act_q && st_q == osp_pkg::ST_IDLE)
    else $error("inactive edge missing at duty match");

  a_init_trig_both: assert property (@(posedge clk_i) disable iff (reset_i) // RL5 RL9
    quiet && cen && st_q == osp_pkg::ST_INIT |=>
      compare0_trigger_o == $past(hit0) && compare1_trigger_o == $past(hit1))
    else $error("compare trigger lost in inactive phase");

  a_irq_flag_set: assert property (@(posedge clk_i) disable iff (reset_i) // RL6
    compare0_trigger_o |=> irq_flag[0] && (irq_o || !irq_en[0]))
    else $error("compare0 event did not set flag or interrupt");

  a_irq_flag_b: assert property (@(posedge clk_i) disable iff (reset_i) // RL6
    compare1_trigger_o |=> irq_flag[1] && (irq_o || !irq_en[1]))
    else $error("compare1 event did not set flag or interrupt");

  a_trig_start: assert property (@(posedge clk_i) disable iff (reset_i) // RL7 RL8
    !wr_cnt && hw_start |=> st_q == osp_pkg::ST_INIT && cnt_q == 16'h0000)
    else $error("trigger did not clear and start counter");

  a_capture_aligned: assert property (@(posedge clk_i) disable iff (reset_i) // RL14
    cap_ev |-> cen)
    else $error("capture clear outside selected enable");

  a_hold_no_cen: assert property (@(posedge clk_i) disable iff (reset_i) // RL15
    quiet && !cen |=> $stable(cnt_q) && !compare0_trigger_o && !compare1_trigger_o)
    else $error("counter moved without clock enable");

  a_duty_one: assert property (@(posedge clk_i) disable iff (reset_i) // RL10
    s_init_hit ##1 (quiet && cen && duty_q == 16'h0001) |=> !act_q)
    else $error("duty of one did not end the pulse at once");

  a_idle_stop: assert property (@(posedge clk_i) disable iff (reset_i) // RL16
    quiet && st_q == osp_pkg::ST_IDLE |=> $stable(cnt_q) && !act_q)
    else $error("idle channel counted or drove active");

  a_init_wait: assert property (@(posedge clk_i) disable iff (reset_i) // RL8
    s_init_wait |=> st_q == osp_pkg::ST_INIT && !act_q)
    else $error("initial phase left early or went active");

  a_pulse_hold: assert property (@(posedge clk_i) disable iff (reset_i) // RL4
    s_pulse_hold |=> st_q == osp_pkg::ST_PULSE && act_q)
    else $error("pulse ended before duty match");

  a_disabled_idle: assert property (@(posedge clk_i) disable iff (reset_i) // RL16
    !ch_en |=> st_q == osp_pkg::ST_IDLE && !act_q)
    else $error("disabled channel not idle");

  a_updown_refused: assert property (@(posedge clk_i) disable iff (reset_i) // RL1
    ch_en && wr_cnt && !sw_mode && st_q == osp_pkg::ST_IDLE |=> st_q == osp_pkg::ST_IDLE)
    else $error("counter write started a cycle outside software mode");

  a_start_on_cen: assert property (@(posedge clk_i) disable iff (reset_i) // RL14 RL15
    hw_mode && !cen && !wr_cnt && st_q == osp_pkg::ST_IDLE |=> st_q == osp_pkg::ST_IDLE)
    else $error("trigger start outside selected enable");

endmodule // osp_channel

`default_nettype wire

// ===== logic/osp_irq.sv
// Sticky interrupt flags with write-one-to-clear and an enable mask.
// Assumes write strobes are single-cycle and taken at the APB access edge.
`default_nettype none
`timescale 1ns/100ps

module osp_irq (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [1:0] event_i,
  input  wire logic       flag_we_i,
  input  wire logic       en_we_i,
  input  wire logic [1:0] wdata_i,
  output logic      [1:0] flag_o,
  output logic      [1:0] en_o,
  output logic            irq_o
);

  logic [1:0] flag_d;
  logic [1:0] en_d;
  logic       irq_d;

  // A new event beats a simultaneous clear
  always_comb begin
    flag_d = flag_o;
    if (flag_we_i) begin
      flag_d = flag_o & ~wdata_i;
    end
    flag_d = flag_d | event_i; // RL6
    en_d   = en_we_i ? wdata_i : en_o;
    irq_d  = |(flag_d & en_d); // RL6
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flag_o <= 2'h0;
      en_o   <= 2'h0;
      irq_o  <= 1'b0;
    end else begin
      flag_o <= flag_d;
      en_o   <= en_d;
      irq_o  <= irq_d;
    end
  end

endmodule // osp_irq

`default_nettype wire

// ===== tb/osp_far_end.sv
// Far-side model: clock enable source, chain neighbour and capture unit.
// Assumes one clock; bench requests are one-cycle strobes after an edge.
`timescale 1ns/100ps
`default_nettype none

module osp_far_end (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       chain_req_i,
  input  wire logic       cap_req_i,
  input  wire logic [3:0] delay_i,
  output logic      [7:0] cen_o,
  output logic            chain_o,
  output logic            capture_o
);
  logic [7:0] div_q;
  logic [3:0] wait_q;
  logic       busy_q;
  logic       kind_q;

  // Enable k fires when the 8-bit divider count is a multiple of k+1
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      cen_o[k] = (div_q % (k + 1)) == 0;
    end
  end

  // Delay lets the bench pick a prompt or a slow trigger source
  always_ff @(posedge clk_i) begin
    chain_o   <= 1'b0;
    capture_o <= 1'b0;
    if (reset_i) begin
      div_q  <= 8'h00;
      busy_q <= 1'b0;
      wait_q <= 4'h0;
      kind_q <= 1'b0;
    end else begin
      div_q <= div_q + 8'h01;
      if (chain_req_i || cap_req_i) begin
        busy_q <= 1'b1;
        wait_q <= delay_i;
        kind_q <= cap_req_i;
      end else if (busy_q && wait_q == 4'h0) begin
        busy_q    <= 1'b0;
        capture_o <= kind_q;
        chain_o   <= !kind_q;
      end else if (busy_q) begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end
endmodule // osp_far_end

`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the one-shot pulse channel over APB.
// Assumes the far-side model supplies enables and trigger pulses.
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic        clk_i;
  logic        reset_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        pulse;
  logic        c0;
  logic        c1;
  logic        irq;
  logic        chain;
  logic        cap;
  logic        chain_req;
  logic        cap_req;
  logic        pulse_q;
  logic        err;
  logic [7:0]  paddr;
  logic [7:0]  cen;
  logic [3:0]  dly;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  int          errors;
  int          cmp_count;
  int          cyc;
  int          c0n;
  int          c1n;
  int          rise_at;
  int          fall_at;
  int          c1_at;
  int          wcyc;
  int          per;
  int          dty;
  logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [31:0] rv [7] = '{32'h800, 32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'h0};

  osp_channel u_osp_channel (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .cluster_clock_enable_i(cen),
    .chain_trigger_in_i(chain), .external_capture_trigger_i(cap),
    .pulse_o(pulse), .compare0_trigger_o(c0), .compare1_trigger_o(c1), .irq_o(irq));

  osp_far_end u_osp_far_end (
    .clk_i(clk_i), .reset_i(reset_i), .chain_req_i(chain_req), .cap_req_i(cap_req),
    .delay_i(dly), .cen_o(cen), .chain_o(chain), .capture_o(cap));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Edge index of each launch: value of cyc seen at the launching edge
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    pulse_q <= pulse;
    if (c0 === 1'b1) c0n <= c0n + 1;
    if (c1 === 1'b1) c1n <= c1n + 1;
    if (c1 === 1'b1 && c1_at < 0) c1_at <= cyc - 1;
    if (pulse === 1'b1 && pulse_q === 1'b0) rise_at <= cyc - 1;
    if (pulse === 1'b0 && pulse_q === 1'b1) fall_at <= cyc - 1;
  end

  task automatic complete_run;
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    rd = prdata;
    err = pslverr;
    wcyc = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cfg(input int p, input int d, input logic [31:0] ctrl);
    per = p;
    dty = d;
    apb(1'b1, osp_pkg::ADDR_PERIOD, p);
    apb(1'b1, osp_pkg::ADDR_DUTY, d);
    apb(1'b1, osp_pkg::ADDR_IRQ_EN, 32'h3);
    apb(1'b1, osp_pkg::ADDR_CTRL, ctrl);
  endtask

  // Kind 0 software write, 1 chain trigger, 2 capture event
  task automatic run(input int kind, input int w, input int div);
    int n;
    c0n = 0;
    c1n = 0;
    c1_at = -1;
    fall_at = -1;
    if (kind == 0) apb(1'b1, osp_pkg::ADDR_COUNTER, w);
    else begin
      @(posedge clk_i);
      chain_req <= (kind == 1);
      cap_req <= (kind == 2);
      @(posedge clk_i);
      chain_req <= 1'b0;
      cap_req <= 1'b0;
    end
    n = 0;
    while (fall_at < 0 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    repeat (12) @(posedge clk_i);
    if (kind == 0 && div == 1) chk(rise_at - wcyc, per - w);
    chk(fall_at - rise_at, dty * div);
    chk(c0n, 1);
    chk(c1n, (kind == 0 && w > dty - 1) ? 1 : 2);
    if (c1n == 2) chk(rise_at - c1_at, (per - dty) * div);
    chk({31'b0, pulse}, 0);
    apb(1'b0, osp_pkg::ADDR_STATUS, 32'h0);
    chk(rd[1:0], 0);
  endtask

  task automatic chip_reset;
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    complete_run;
  end

  initial begin
    {psel, penable, pwrite, chain_req, cap_req, pulse_q} = '0;
    {paddr, pwdata, dly} = '0;
    {errors, cmp_count, cyc, c0n, c1n, rise_at, fall_at} = '0;
    c1_at = -1;
    reset_i = 1'b1;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'b0, err}, 1);
    chk(rd, 0);
    cfg(4, 2, 32'h803);
    run(0, 1, 1);
    apb(1'b0, osp_pkg::ADDR_IRQ_FLAG, 32'h0);
    chk(rd, 3);
    chk({31'b0, irq}, 1);
    apb(1'b1, osp_pkg::ADDR_IRQ_FLAG, 32'h1);
    apb(1'b0, osp_pkg::ADDR_IRQ_FLAG, 32'h0);
    chk(rd, 2);
    apb(1'b1, osp_pkg::ADDR_IRQ_EN, 32'h1);
    repeat (2) @(posedge clk_i);
    chk({31'b0, irq}, 0);
    apb(1'b1, osp_pkg::ADDR_IRQ_EN, 32'h3);
    run(0, 1, 1);
    run(0, 3, 1);
    cfg(8, 6, 32'h803);
    apb(1'b1, osp_pkg::ADDR_COUNTER, 32'h0);
    run(0, 2, 1);
    apb(1'b1, osp_pkg::ADDR_CTRL, 32'h80B);
    c0n = 0;
    apb(1'b1, osp_pkg::ADDR_COUNTER, 32'h0);
    repeat (20) @(posedge clk_i);
    chk(c0n, 0);
    chk({31'b0, pulse}, 0);
    apb(1'b1, osp_pkg::ADDR_CTRL, 32'h00B);
    repeat (2) @(posedge clk_i);
    chk({31'b0, pulse}, 1);
    chip_reset();
    cfg(4, 1, 32'h807);
    run(1, 0, 1);
    run(2, 0, 1);
    dly = 4'h3;
    cfg(4, 1, 32'h907);
    run(2, 0, 2);
    run(1, 0, 2);
    cfg(4, 2, 32'h903);
    run(0, 0, 2);
    complete_run;
  end
endmodule // tb

`default_nettype wire
